// ---- logic/cscs_atr_class.sv ----
`timescale 1ns/10ps
// ============================================================================
// Answer-to-reset walker that picks out the class indication byte
module cscs_atr_class
  import cscs_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clr_i,
  input wire logic [7:0] byte_i,
  input wire logic byte_valid_i,
  output logic found_o,
  output logic [cscs_pkg::CLS_W-1:0] classes_o
);
  import cscs_pkg::*;

  logic [3:0] pend_r, pend_nxt;
  logic [3:0] grp_r, grp_nxt;
  logic t15_r, t15_nxt;
  logic hdr_r, hdr_nxt;
  logic found_r, found_nxt;
  logic [CLS_W-1:0] cls_r, cls_nxt;

  // Pending mask holds which of TA, TB, TC, TD are still to come
  always_comb
  begin
    pend_nxt = pend_r;
    grp_nxt = grp_r;
    t15_nxt = t15_r;
    hdr_nxt = hdr_r;
    found_nxt = found_r;
    cls_nxt = cls_r;
    if (clr_i)
    begin
      pend_nxt = 4'h0;
      grp_nxt = 4'h1;
      t15_nxt = 1'b0;
      hdr_nxt = 1'b1;
      found_nxt = 1'b0;
      cls_nxt = '0;
    end
    else if (byte_valid_i)
    begin
      if (hdr_r)
      begin
        hdr_nxt = 1'b0; // Format byte announces the first group
        pend_nxt = byte_i[7:4];
      end
      else if (pend_r[0])
      begin
        pend_nxt = {pend_r[3:1], 1'b0};
        // Only the first TA after T=15, group three or later
        if (t15_r && !found_r && grp_r >= CLS_IDX_FIRST)
        begin
          found_nxt = 1'b1;
          cls_nxt = byte_i[CLS_W-1:0];
        end
      end
      else if (pend_r[1])
      begin
        pend_nxt = {pend_r[3:2], 2'h0};
      end
      else if (pend_r[2])
      begin
        pend_nxt = {pend_r[3], 3'h0};
      end
      else if (pend_r[3])
      begin
        pend_nxt = byte_i[7:4];
        grp_nxt = grp_r + 4'h1;
        if (byte_i[3:0] == PROTO_GLOBAL && !t15_r)
        begin
          t15_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pend_r <= 4'h0;
      grp_r <= 4'h1;
      t15_r <= 1'b0;
      hdr_r <= 1'b1;
      found_r <= 1'b0;
      cls_r <= '0;
    end
    else
    begin
      pend_r <= pend_nxt;
      grp_r <= grp_nxt;
      t15_r <= t15_nxt;
      hdr_r <= hdr_nxt;
      found_r <= found_nxt;
      cls_r <= cls_nxt;
    end
  end

  assign found_o = found_r;
  assign classes_o = cls_r;

endmodule

// ---- logic/cscs_pkg.sv ----
// How it works
// - Class selection finishes before any command traffic is allowed.
// - First activation uses the lowest-voltage class the terminal has.
// - No answer-to-reset: deactivate, reactivate at next higher supported class; here only the next class up is tried, else reject.
// - Answer at first applied class is parsed for supported classes.
// - Current class unsupported but common class exists: reactivate at that class.
// - No common class: block commands; card may be deactivated.
// - Corrupted answer: reset at least three times at the same class.
// - After three corrupted answers, retry only at next higher class.
// - Class bits: 0 A, 1 B, 2 C, 3 D, 4 E reserved.
// - Deselect applications asking more power than advertised; not done here, deselect is left upstream.
package cscs_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_US = 200;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int RST_HOLD_US = 120;
  localparam int RST_HOLD_CYC = RST_HOLD_US * CLK_MHZ;
  localparam int ATR_WAIT_US = 12000;
  localparam int ATR_WAIT_CYC = ATR_WAIT_US * CLK_MHZ;
  localparam int DEACT_US = 100;
  localparam int DEACT_CYC = DEACT_US * CLK_MHZ;
  // Half period of the card clock, 100 MHz / 26 is about 3.85 MHz
  localparam logic [4:0] CARD_CLK_HALF = 5'h0d;
  localparam int CNT_W = 21;

  // ==========================================================================
  // Class indication byte layout
  localparam int CLS_A_BIT = 0;
  localparam int CLS_B_BIT = 1;
  localparam int CLS_C_BIT = 2;
  localparam int CLS_D_BIT = 3;
  localparam int CLS_E_BIT = 4;
  localparam int CLS_W = 5;
  localparam logic [3:0] PROTO_GLOBAL = 4'hf;
  localparam logic [3:0] CLS_IDX_FIRST = 4'h3;

  // Consecutive corrupted answers tolerated at one class
  localparam logic [1:0] RETRY_MAX = 2'h3;

  // Class order index, lowest voltage first
  typedef enum logic [1:0] {
    CIDX_D,
    CIDX_C,
    CIDX_B,
    CIDX_A
  } cscs_cidx_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_POWER,
    ST_RESET,
    ST_WAIT,
    ST_RECV,
    ST_EVAL,
    ST_DEACT,
    ST_READY,
    ST_FAIL
  } cscs_state_t;

  // Bit position in the indication byte for a class order index
  function automatic logic [2:0] cidx_bit(input logic [1:0] idx);
    unique case (idx)
      2'h0: cidx_bit = 3'(CLS_D_BIT);
      2'h1: cidx_bit = 3'(CLS_C_BIT);
      2'h2: cidx_bit = 3'(CLS_B_BIT);
      default: cidx_bit = 3'(CLS_A_BIT);
    endcase
  endfunction

  // Lowest-voltage class present in a mask; bit 2 of result flags found
  function automatic logic [2:0] lowest_class(input logic [CLS_W-1:0] mask);
    lowest_class = 3'h0;
    for (int k = 3; k >= 0; k--)
    begin
      if (mask[cidx_bit(2'(k))])
      begin
        lowest_class = {1'b1, 2'(k)};
      end
    end
  endfunction

endpackage

// ---- logic/cscs_selector.sv ----
`timescale 1ns/10ps
// ============================================================================
// Terminal-side supply class selection for a contact card
module cscs_selector
  import cscs_pkg::*;
#(
  parameter int SETTLE_CYCLES = cscs_pkg::SETTLE_CYC,
  parameter int RST_HOLD_CYCLES = cscs_pkg::RST_HOLD_CYC,
  parameter int ATR_WAIT_CYCLES = cscs_pkg::ATR_WAIT_CYC,
  parameter int DEACT_CYCLES = cscs_pkg::DEACT_CYC
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [cscs_pkg::CLS_W-1:0] term_classes_i,
  input wire logic [7:0] atr_byte_i,
  input wire logic atr_byte_valid_i,
  input wire logic atr_end_i,
  input wire logic atr_corrupt_i,
  input wire logic card_io_i,
  output logic card_vcc_en_o,
  output logic [cscs_pkg::CLS_W-1:0] card_class_o,
  output logic card_rst_n_o,
  output logic card_clk_o,
  output logic busy_o,
  output logic cmd_allow_o,
  output logic rejected_o,
  output logic no_common_o
);
  import cscs_pkg::*;

  // ==========================================================================
  // State
  cscs_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [1:0] cls_r, cls_nxt;
  logic [1:0] tries_r, tries_nxt;
  logic first_r, first_nxt;
  logic stop_r, stop_nxt;
  logic rej_r, rej_nxt;
  logic nocom_r, nocom_nxt;
  logic vcc_r, vcc_nxt;
  logic rst_n_r, rst_n_nxt;
  logic [CLS_W-1:0] sel_r, sel_nxt;
  logic [4:0] div_r, div_nxt;
  logic cclk_r, cclk_nxt;
  logic io_s1_r, io_s2_r, io_s3_r;
  logic io_fall;
  logic dec_clr;
  logic card_found;
  logic [CLS_W-1:0] card_cls;
  logic [2:0] init_cls;
  logic [2:0] common_cls;
  logic up_ok;
  logic [1:0] up_idx;

  cscs_atr_class cscs_atr_class_inst (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(dec_clr),
    .byte_i(atr_byte_i),
    .byte_valid_i(atr_byte_valid_i),
    .found_o(card_found),
    .classes_o(card_cls)
  );

  // ==========================================================================
  // Card I/O synchroniser; only the second and third stages feed logic
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      io_s1_r <= 1'b1;
      io_s2_r <= 1'b1;
      io_s3_r <= 1'b1;
    end
    else
    begin
      io_s1_r <= card_io_i;
      io_s2_r <= io_s1_r;
      io_s3_r <= io_s2_r;
    end
  end

  // Start bit of the first answer byte
  assign io_fall = io_s3_r && !io_s2_r;
  assign dec_clr = (state_r == ST_RESET);

  // ==========================================================================
  // Class arithmetic
  always_comb
  begin
    init_cls = lowest_class(term_classes_i);
    common_cls = lowest_class(term_classes_i & card_cls);
    up_idx = cls_r + 2'h1;
    up_ok = (cls_r != 2'(CIDX_A)) && term_classes_i[cidx_bit(up_idx)];
  end

  // ==========================================================================
  // Sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + CNT_W'(1);
    cls_nxt = cls_r;
    tries_nxt = tries_r;
    first_nxt = first_r;
    stop_nxt = stop_r;
    rej_nxt = rej_r;
    nocom_nxt = nocom_r;
    unique case (state_r)
      ST_IDLE:
      begin
        cnt_nxt = '0;
        if (start_i)
        begin
          rej_nxt = 1'b0;
          nocom_nxt = 1'b0;
          tries_nxt = 2'h0;
          first_nxt = 1'b1;
          stop_nxt = 1'b0;
          if (init_cls[2])
          begin
            cls_nxt = init_cls[1:0];
            state_nxt = ST_POWER;
          end
          else
          begin
            rej_nxt = 1'b1; // Terminal offers none of classes A to D
            state_nxt = ST_FAIL;
          end
        end
      end
      ST_POWER:
      begin
        if (cnt_r == CNT_W'(SETTLE_CYCLES - 1))
        begin
          cnt_nxt = '0;
          state_nxt = ST_RESET;
        end
      end
      ST_RESET:
      begin
        if (cnt_r == CNT_W'(RST_HOLD_CYCLES - 1))
        begin
          cnt_nxt = '0;
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (io_fall || atr_byte_valid_i)
        begin
          state_nxt = ST_RECV;
        end
        else if (cnt_r == CNT_W'(ATR_WAIT_CYCLES - 1))
        begin
          cnt_nxt = '0;
          tries_nxt = 2'h0;
          state_nxt = ST_DEACT;
          if (up_ok)
          begin
            cls_nxt = up_idx;
          end
          else
          begin
            stop_nxt = 1'b1;
            rej_nxt = 1'b1;
          end
        end
      end
      ST_RECV:
      begin
        cnt_nxt = '0;
        if (atr_corrupt_i)
        begin
          tries_nxt = tries_r + 2'h1;
          if (tries_r + 2'h1 < RETRY_MAX)
          begin
            state_nxt = ST_RESET;
          end
          else
          begin
            tries_nxt = 2'h0;
            state_nxt = ST_DEACT;
            if (up_ok)
            begin
              cls_nxt = up_idx;
            end
            else
            begin
              stop_nxt = 1'b1;
              rej_nxt = 1'b1;
            end
          end
        end
        else if (atr_end_i)
        begin
          tries_nxt = 2'h0;
          state_nxt = ST_EVAL;
        end
      end
      ST_EVAL:
      begin
        cnt_nxt = '0;
        // Class byte absent means no restriction is claimed
        if (!card_found || card_cls[cidx_bit(cls_r)])
        begin
          state_nxt = ST_READY;
        end
        else if (first_r && common_cls[2])
        begin
          first_nxt = 1'b0;
          cls_nxt = common_cls[1:0];
          state_nxt = ST_DEACT;
        end
        else
        begin
          nocom_nxt = 1'b1;
          stop_nxt = 1'b1;
          state_nxt = ST_DEACT;
        end
      end
      ST_DEACT:
      begin
        if (cnt_r == CNT_W'(DEACT_CYCLES - 1))
        begin
          cnt_nxt = '0;
          state_nxt = stop_r ? ST_FAIL : ST_POWER;
        end
      end
      ST_READY:
      begin
        cnt_nxt = '0;
      end
      ST_FAIL:
      begin
        cnt_nxt = '0;
        if (start_i)
        begin
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Supply, reset and class pins follow the next state so they change with the state
  always_comb
  begin
    vcc_nxt = state_nxt inside {ST_POWER, ST_RESET, ST_WAIT, ST_RECV, ST_EVAL, ST_READY};
    rst_n_nxt = state_nxt inside {ST_WAIT, ST_RECV, ST_EVAL, ST_READY};
    sel_nxt = vcc_nxt ? (CLS_W'(1) << cidx_bit(cls_nxt)) : '0;
    // Clock forced low one cycle after the supply is switched off
    div_nxt = (!vcc_r || div_r == CARD_CLK_HALF - 5'h01) ? 5'h00 : div_r + 5'h01;
    cclk_nxt = !vcc_r ? 1'b0 : (div_r == CARD_CLK_HALF - 5'h01) ? !cclk_r : cclk_r;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      cls_r <= 2'h0;
      tries_r <= 2'h0;
      first_r <= 1'b1;
      stop_r <= 1'b0;
      rej_r <= 1'b0;
      nocom_r <= 1'b0;
      vcc_r <= 1'b0;
      rst_n_r <= 1'b0;
      sel_r <= '0;
      div_r <= 5'h00;
      cclk_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cls_r <= cls_nxt;
      tries_r <= tries_nxt;
      first_r <= first_nxt;
      stop_r <= stop_nxt;
      rej_r <= rej_nxt;
      nocom_r <= nocom_nxt;
      vcc_r <= vcc_nxt;
      rst_n_r <= rst_n_nxt;
      sel_r <= sel_nxt;
      div_r <= div_nxt;
      cclk_r <= cclk_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign card_vcc_en_o = vcc_r;
  assign card_class_o = sel_r;
  assign card_rst_n_o = rst_n_r;
  assign card_clk_o = cclk_r;
  assign busy_o = !(state_r inside {ST_IDLE, ST_READY, ST_FAIL});
  assign cmd_allow_o = (state_r == ST_READY); // deselect is upstream
  assign rejected_o = rej_r;
  assign no_common_o = nocom_r;

endmodule

// ---- verification/cscs_card_model.sv ----
`timescale 1ns/10ps
// ============================================================================
// Card model: answers each reset release unless quiet at the applied class
module cscs_card_model (
  input wire logic clk_i,
  input wire logic vcc_en_i,
  input wire logic [4:0] class_i,
  input wire logic rst_n_i,
  input wire logic card_clk_i,
  input wire logic clr_i,
  input wire logic [4:0] ind_i,
  input wire logic [4:0] quiet_i,
  input wire logic [3:0] bad_i,
  input wire logic alt_i,
  output logic io_o,
  output logic [7:0] byte_o,
  output logic valid_o,
  output logic end_o,
  output logic corrupt_o
);
  int answers;
  logic [7:0] atr [4];

  initial
  begin
    io_o = 1'b1;
    byte_o = 8'h00;
    valid_o = 1'b0;
    end_o = 1'b0;
    corrupt_o = 1'b0;
    answers = 0;
  end

  // Corrupt count restarts with each test
  always @(posedge clr_i)
    answers = 0;

  // Format, two chained indicators, global group, then the class byte;
  // the alternate answer carries only TB and TC of group one and no class byte
  always @(posedge rst_n_i)
  begin
    if (alt_i)
      atr = '{8'h61, 8'h00, 8'h00, 8'hff};
    else
      atr = '{8'h80, 8'h80, 8'h1f, {3'h0, ind_i}};
    if (vcc_en_i && !(|(class_i & quiet_i)))
    begin
      repeat (4) @(posedge card_clk_i);
      @(posedge clk_i);
      #1 io_o = 1'b0;
      for (int k = 0; k < 4; k++)
      begin
        repeat (2) @(posedge clk_i);
        #1 byte_o = atr[k];
        valid_o = 1'b1;
        @(posedge clk_i);
        #1 valid_o = 1'b0;
        byte_o = ~byte_o; // Stale byte must not look valid
      end
      @(posedge clk_i);
      #1 corrupt_o = answers < int'(bad_i);
      end_o = answers >= int'(bad_i);
      answers++;
      @(posedge clk_i);
      #1 corrupt_o = 1'b0;
      end_o = 1'b0;
      io_o = 1'b1; // Pull-up level
    end
  end
endmodule

// ---- verification/cscs_selector_chk.sv ----
`timescale 1ns/10ps
// ============================================================================
// Port checks of the supply class sequence
module cscs_selector_chk
  import cscs_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [cscs_pkg::CLS_W-1:0] term_classes_i,
  input wire logic [7:0] atr_byte_i,
  input wire logic atr_byte_valid_i,
  input wire logic atr_end_i,
  input wire logic atr_corrupt_i,
  input wire logic card_io_i,
  input wire logic card_vcc_en_o,
  input wire logic [cscs_pkg::CLS_W-1:0] card_class_o,
  input wire logic card_rst_n_o,
  input wire logic card_clk_o,
  input wire logic busy_o,
  input wire logic cmd_allow_o,
  input wire logic rejected_o,
  input wire logic no_common_o
);
  logic [1:0] bad_r, bad_nxt;
  logic step_r, step_nxt, vcc_q_r;
  logic [4:0] last_r, last_nxt, lo_exp;

  // Lowest voltage first, worked out apart from the design's helper
  assign lo_exp = term_classes_i[3] ? 5'h08 : term_classes_i[2] ? 5'h04 :
    term_classes_i[1] ? 5'h02 : {4'h0, term_classes_i[0]};

  // Corrupt answers at one class; power-off or a good answer clears them
  always_comb
  begin
    bad_nxt = bad_r;
    step_nxt = step_r;
    last_nxt = card_vcc_en_o ? card_class_o : last_r;
    if (!card_vcc_en_o)
      bad_nxt = 2'h0;
    else if (atr_corrupt_i && card_rst_n_o)
      bad_nxt = bad_r + 2'h1;
    else if (atr_end_i)
      bad_nxt = 2'h0;
    if ((card_vcc_en_o && !vcc_q_r) || rejected_o)
      step_nxt = 1'b0;
    else if (atr_corrupt_i && card_rst_n_o && bad_r == 2'h2)
      step_nxt = 1'b1;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bad_r <= 2'h0;
      step_r <= 1'b0;
      vcc_q_r <= 1'b0;
      last_r <= 5'h00;
    end
    else
    begin
      bad_r <= bad_nxt;
      step_r <= step_nxt;
      vcc_q_r <= card_vcc_en_o;
      last_r <= last_nxt;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_idle_start;
    start_i && !busy_o && !card_vcc_en_o && !cmd_allow_o && !rejected_o && !no_common_o
      && lo_exp != 5'h00;
  endsequence
  sequence s_bad;
    atr_corrupt_i && card_rst_n_o && card_vcc_en_o;
  endsequence

  cmd_gate_a: assert property (cmd_allow_o |-> card_vcc_en_o
    && card_rst_n_o && !busy_o) else $error("commands allowed before the class settled");
  cold_hold_a: assert property ($rose(card_vcc_en_o) |-> !card_rst_n_o [*8])
    else $error("reset released too soon after power-up");
  first_class_a: assert property (s_idle_start |=> card_vcc_en_o
    && card_class_o == lo_exp) else $error("first class not the lowest available");
  power_class_a: assert property (card_vcc_en_o |-> $onehot(card_class_o)
    && |(card_class_o & term_classes_i & 5'h0f)) else $error("unsupported class applied");
  supply_off_a: assert property (!card_vcc_en_o |-> card_class_o == 5'h00
    && !card_rst_n_o) else $error("pins active with supply off");
  ready_class_a: assert property (cmd_allow_o |-> |(card_class_o & term_classes_i))
    else $error("settled on a class the terminal lacks");
  warm_retry_a: assert property (s_bad ##0 bad_r != 2'h2 |-> ##[1:4]
    !card_rst_n_o && card_vcc_en_o && card_class_o == last_r) else $error("no retry at same class");
  third_step_a: assert property (s_bad ##0 bad_r == 2'h2 |-> ##[1:4] !card_vcc_en_o)
    else $error("no power-down after third corrupt answer");
  step_next_a: assert property (card_vcc_en_o && !vcc_q_r && step_r
    |-> card_class_o == (last_r >> 1)) else $error("retry not at next higher class");
  nc_block_a: assert property (no_common_o |-> !cmd_allow_o)
    else $error("commands allowed without common class");
  nc_deact_a: assert property ($rose(no_common_o) |-> ##[0:4] !card_vcc_en_o)
    else $error("card left powered without common class");
  // Card clock stops one cycle after the supply, and toggles every 13 cycles while powered
  clk_off_a: assert property (!vcc_q_r |-> !card_clk_o)
    else $error("card clock running with supply off");
  clk_runs_a: assert property (card_vcc_en_o && $stable(card_clk_o) |->
    ##[1:13] ($changed(card_clk_o) || !card_vcc_en_o))
    else $error("card clock stuck while powered");
endmodule

// ---- verification/cscs_selector_tb_top.sv ----
`timescale 1ns/10ps
// ============================================================================
// Self-checking bench for the supply class sequencer
module cscs_selector_tb_top;
  import cscs_pkg::*;
  logic clk_i, sys_rst_i, start_i, card_io_i, card_vcc_en_o, card_rst_n_o, card_clk_o;
  logic atr_byte_valid_i, atr_end_i, atr_corrupt_i, busy_o, cmd_allow_o, rejected_o;
  logic no_common_o, clr, first_pend, rst_prev, alt;
  logic [7:0] atr_byte_i;
  logic [4:0] term_classes_i, card_class_o, ind, quiet, first_cls, t, c;
  logic [3:0] bad;
  int mismatches, cmp_count, cycles, d_resets, seed, tnum, s, ln;

  cscs_selector #(.SETTLE_CYCLES(20), .RST_HOLD_CYCLES(40), .ATR_WAIT_CYCLES(200),
    .DEACT_CYCLES(10)) cscs_selector_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .start_i(start_i), .term_classes_i(term_classes_i), .atr_byte_i(atr_byte_i),
    .atr_byte_valid_i(atr_byte_valid_i), .atr_end_i(atr_end_i),
    .atr_corrupt_i(atr_corrupt_i), .card_io_i(card_io_i), .card_vcc_en_o(card_vcc_en_o),
    .card_class_o(card_class_o), .card_rst_n_o(card_rst_n_o), .card_clk_o(card_clk_o),
    .busy_o(busy_o), .cmd_allow_o(cmd_allow_o), .rejected_o(rejected_o),
    .no_common_o(no_common_o));
  cscs_card_model cscs_card_model_inst (.clk_i(clk_i), .vcc_en_i(card_vcc_en_o),
    .class_i(card_class_o), .rst_n_i(card_rst_n_o), .card_clk_i(card_clk_o), .clr_i(clr),
    .ind_i(ind), .quiet_i(quiet), .bad_i(bad), .alt_i(alt), .io_o(card_io_i),
    .byte_o(atr_byte_i), .valid_o(atr_byte_valid_i), .end_o(atr_end_i),
    .corrupt_o(atr_corrupt_i));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Checking helpers
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp_cls(input logic [4:0] got, input logic [4:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_cls({4'h0, got}, {4'h0, exp});
  endtask
  function automatic logic [4:0] low1h(input logic [4:0] m);
    return m[3] ? 5'h08 : m[2] ? 5'h04 : m[1] ? 5'h02 : {4'h0, m[0]};
  endfunction
  // Outcome as {rejected, no common, final class}
  function automatic logic [6:0] end_state(input logic [4:0] tm, input logic [4:0] cm);
    if (low1h(tm) == 5'h00)
      return 7'h40;
    if ((low1h(tm) & cm) != 5'h00)
      return {2'h0, low1h(tm)};
    if (low1h(tm & cm) != 5'h00)
      return {2'h0, low1h(tm & cm)};
    return 7'h20;
  endfunction

  // Hang guard, well above the longest test sequence
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  // Sample at the falling edge, once registered outputs have settled
  always @(negedge clk_i)
  begin
    if (card_vcc_en_o === 1'b1 && first_pend)
    begin
      first_cls = card_class_o;
      first_pend = 1'b0;
    end
    if (card_rst_n_o === 1'b1 && rst_prev !== 1'b1 && card_class_o === 5'h08)
      d_resets++;
    rst_prev = card_rst_n_o;
  end

  // Short reset, one start pulse, then the outcome
  task automatic run(input logic [4:0] tm, cm, qm, input logic [3:0] b,
    input logic [6:0] e, input logic [4:0] dr);
    int n;
    @(posedge clk_i);
    #1 sys_rst_i = 1'b1;
    term_classes_i = tm;
    ind = cm;
    quiet = qm;
    bad = b;
    clr = 1'b1;
    @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    clr = 1'b0;
    first_pend = 1'b1;
    first_cls = 5'h00;
    d_resets = 0;
    start_i = 1'b1;
    @(posedge clk_i);
    #1 start_i = 1'b0;
    n = 0;
    while (cmd_allow_o !== 1'b1 && rejected_o !== 1'b1 && no_common_o !== 1'b1 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    repeat (30) @(posedge clk_i);
    #1;
    cmp_flag(n < 3000, 1'b1);
    cmp_cls(first_cls, low1h(tm));
    cmp_cls(card_class_o, e[4:0]);
    cmp_flag(rejected_o, e[6]);
    cmp_flag(no_common_o, e[5]);
    cmp_flag(cmd_allow_o, e[6:5] == 2'h0);
    cmp_cls(5'(d_resets), dr);
    tnum++;
    $display("test %0d done", tnum);
  endtask

  initial
  begin
    seed = 32'hdda28ae8;
    {mismatches, cmp_count, cycles, tnum, d_resets} = '0;
    sys_rst_i = 1'b1;
    {start_i, clr, first_pend, rst_prev, alt} = 5'h00;
    {term_classes_i, ind, quiet, first_cls, bad} = '0;
    repeat (20) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    run(5'h1f, 5'h08, 5'h00, 4'h0, 7'h08, 5'h01);
    run(5'h0e, 5'h02, 5'h00, 4'h0, 7'h02, 5'h01);
    run(5'h0c, 5'h0c, 5'h08, 4'h0, 7'h04, 5'h01);
    run(5'h0c, 5'h0c, 5'h00, 4'h3, 7'h04, 5'h03);
    run(5'h0c, 5'h0c, 5'h00, 4'h2, 7'h08, 5'h03);
    run(5'h08, 5'h0c, 5'h00, 4'h3, 7'h40, 5'h03);
    run(5'h08, 5'h01, 5'h00, 4'h0, 7'h20, 5'h01);
    run(5'h08, 5'h08, 5'h08, 4'h0, 7'h40, 5'h01);
    run(5'h10, 5'h08, 5'h00, 4'h0, 7'h40, 5'h00);
    run(5'h0a, 5'h0c, 5'h00, 4'h0, 7'h08, 5'h01);
    // Answer with no class byte: the first class is kept
    alt = 1'b1;
    run(5'h0c, 5'h01, 5'h00, 4'h0, 7'h08, 5'h01);
    alt = 1'b0;
    // Random terminal sets against adjacent card sets
    repeat (12)
    begin
      t = 5'($random(seed));
      s = int'($unsigned($random(seed)) % 4);
      ln = 1 + int'($unsigned($random(seed)) % (4 - s));
      c = 5'(((1 << ln) - 1) << s);
      run(t, c, 5'h00, 4'h0, end_state(t, c), {4'h0, low1h(t) == 5'h08});
    end
    wrap_up();
  end
endmodule

bind cscs_selector cscs_selector_chk cscs_selector_chk_inst (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .start_i(start_i), .term_classes_i(term_classes_i),
  .atr_byte_i(atr_byte_i), .atr_byte_valid_i(atr_byte_valid_i), .atr_end_i(atr_end_i),
  .atr_corrupt_i(atr_corrupt_i), .card_io_i(card_io_i), .card_vcc_en_o(card_vcc_en_o),
  .card_class_o(card_class_o), .card_rst_n_o(card_rst_n_o), .card_clk_o(card_clk_o),
  .busy_o(busy_o), .cmd_allow_o(cmd_allow_o), .rejected_o(rejected_o),
  .no_common_o(no_common_o));
